// ==== common/dit_pkg.sv ====
package dit_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned TICK_TIME_US = 1000;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_TIME_US;
  localparam int unsigned DLY_UNIT_MS  = 100;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [5:0] A_OC_LEVEL = 6'h00;
  localparam logic [5:0] A_POL_LO   = 6'h01;
  localparam logic [5:0] A_POL_HI   = 6'h02;
  localparam logic [5:0] A_WIRING   = 6'h03;
  localparam logic [5:0] A_FILTER   = 6'h04;
  localparam logic [5:0] A_VACTIVE  = 6'h05;
  localparam logic [5:0] A_DLY_BASE = 6'h06;
  localparam logic [5:0] A_FN_BASE  = 6'h10;
  localparam logic [5:0] A_VVALUE   = 6'h18;
  localparam logic [5:0] A_CTRL     = 6'h19;
  localparam logic [5:0] A_LEVELS   = 6'h1A;
  localparam logic [5:0] A_CMDSTAT  = 6'h1B;

  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_OC_LEVEL = 16'h0001;
  localparam logic [15:0] RST_FILTER   = 16'h000a;
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam int unsigned POL_DIGIT    = 4;
  localparam int unsigned CF_MODE_LSB  = 0;
  localparam int unsigned CF_STBASE    = 2;
  localparam int unsigned CF_AUX_LSB   = 3;
  localparam int unsigned CF_SRC_LSB   = 6;
  localparam int unsigned CF_COMM_LSB  = 8;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CS_KEYPAD = 2'h0;
  localparam logic [1:0] CS_TERM   = 2'h1;
  localparam logic [1:0] CS_COMM   = 2'h2;
  localparam logic [1:0] CM_VF     = 2'h0;
  localparam logic [1:0] CM_FVC    = 2'h2;
  localparam logic [2:0] AUX_DIG0  = 3'h0;
  localparam logic [2:0] AUX_DIG7  = 3'h7;
  localparam logic [1:0] WM_2W1    = 2'h0;
  localparam logic [1:0] WM_2W2    = 2'h1;
  localparam logic [1:0] WM_3W1    = 2'h2;
  localparam logic [1:0] WM_3W2    = 2'h3;

  localparam int unsigned F_FWD = 1;
  localparam int unsigned F_REV = 2;
  localparam int unsigned F_3W  = 5;
  localparam int unsigned F_KEYPAD = 38;
  localparam int unsigned F_TERM   = 39;
  localparam int unsigned F_COMM   = 40;
  localparam int unsigned F_REVINH = 42;
  localparam int unsigned F_RUNINH = 43;
  localparam int unsigned F_EXTSTP = 44;
  localparam int unsigned F_AUXCLR = 45;
  localparam int unsigned F_SPDTRQ = 47;
  localparam int unsigned F_TRQDIR = 48;
  localparam int unsigned F_MOTOR  = 55;
  localparam int unsigned F_ESTOP  = 60;
  localparam int unsigned F_WPAUSE = 61;
  localparam int unsigned F_WRESET = 62;
  localparam int unsigned F_CRESET = 63;
  localparam int unsigned F_CTRIG  = 64;
  localparam int unsigned F_ECLR   = 65;
  localparam int unsigned F_EHOLD  = 66;
  localparam int unsigned F_LCOUNT = 67;
  localparam int unsigned F_LRESET = 68;
  localparam int unsigned F_VF     = 69;
  localparam int unsigned F_FVC    = 70;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [5:0]  addr;
    logic [15:0] wdata;
  } dit_bus_t;

  typedef struct packed {
    logic [1:0] cmd_src;
    logic [2:0] comm_method;
    logic       run;
    logic       run_rev;
    logic       coast_stop;
    logic       zero_freq;
    logic       ext_stop;
    logic       emer_stop;
    logic       aux_clear;
    logic       torque_mode;
    logic       torque_neg;
    logic       motor2;
    logic [1:0] ctrl_mode;
    logic       wobble_pause;
    logic       wobble_reset;
    logic       count_reset;
    logic       count_en;
    logic       energy_clear;
    logic       energy_hold;
    logic       length_count;
    logic       length_reset;
  } dit_cmd_t;

endpackage : dit_pkg

// ==== hdl/dit_in_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module dit_in_chan (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // level and timebase
  input  wire logic        level_in,
  input  wire logic        tick_in,
  // settings
  input  wire logic [15:0] filt_ms_in,
  input  wire logic [15:0] on_dly_in,
  input  wire logic [15:0] off_dly_in,
  // conditioned level
  output logic             level_out
);

  typedef struct packed {
    logic [15:0] filt_cnt;
    logic        filt_lvl;
    logic [23:0] dly_cnt;
    logic        out;
  } dit_chan_t;

  dit_chan_t   st_r;
  dit_chan_t   st_nxt;
  logic [23:0] target;

  always_comb
  begin
    st_nxt = st_r;
    target = 24'h00_0000;
    // filter: level must hold for the whole filter time
    if (level_in == st_r.filt_lvl)
      st_nxt.filt_cnt = 16'h0000;
    else if (filt_ms_in == 16'h0000)
      st_nxt.filt_lvl = level_in;
    else if (tick_in)
    begin
      if (st_r.filt_cnt + 16'h0001 >= filt_ms_in)
      begin
        st_nxt.filt_lvl = level_in;
        st_nxt.filt_cnt = 16'h0000;
      end
      else
        st_nxt.filt_cnt = st_r.filt_cnt + 16'h0001;
    end
    // delay after the filter, separate times per edge direction
    target = 24'((st_r.filt_lvl ? on_dly_in : off_dly_in) * dit_pkg::DLY_UNIT_MS);
    if (st_r.filt_lvl == st_r.out)
      st_nxt.dly_cnt = 24'h00_0000;
    else if (target == 24'h00_0000)
      st_nxt.out = st_r.filt_lvl;
    else if (tick_in)
    begin
      if (st_r.dly_cnt + 24'h00_0001 >= target)
      begin
        st_nxt.out     = st_r.filt_lvl;
        st_nxt.dly_cnt = 24'h00_0000;
      end
      else
        st_nxt.dly_cnt = st_r.dly_cnt + 24'h00_0001;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign level_out = st_r.out;

endmodule : dit_in_chan
`default_nettype wire

// ==== hdl/dit_input_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module dit_input_top #(
  parameter int unsigned TICK_CYCLES = dit_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // register port
  input  wire dit_pkg::dit_bus_t bus_in,
  output logic [15:0]            rdata_out,
  // terminals
  input  wire logic [7:0]        term_pins_in,
  // drive state
  input  wire logic              running_in,
  input  wire logic              rev_running_in,
  // commands to drive
  output dit_pkg::dit_cmd_t      cmd_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        sync1;
    logic [7:0]        sync2;
    logic [16:0]       tick_cnt;
    logic              tick;
    logic              oc_level;
    logic [15:0]       pol_lo;
    logic [15:0]       pol_hi;
    logic [1:0]        wiring;
    logic [15:0]       filt_ms;
    logic [7:0]        vactive;
    logic [7:0]        vvalue;
    logic [7:0][15:0]  dly;
    logic [7:0][6:0]   fn_sel;
    logic [10:0]       ctrl;
    logic              rev_pre;
    logic              run_r;
    logic              rev_r;
    logic              fwd_prev;
    logic              rev_prev;
    logic [15:0]       rdata;
    dit_pkg::dit_cmd_t cmd;
  } dit_state_t;

  dit_state_t   st_r;
  dit_state_t   st_nxt;
  logic [7:0]   pol_bits;
  logic [7:0]   pre_lvl;
  logic [7:0]   chan_lvl;
  logic [7:0]   act;
  logic [127:0] hit;
  logic         vec;
  logic [1:0]   mode;
  logic [2:0]   aux_src;

  // ---------------------------------------------------------------
  // per-input conditioning
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_chan
      logic [15:0] on_dly;
      logic [15:0] off_dly;
      if (gi < 4)
      begin : g_dly
        assign on_dly  = st_r.dly[2 * gi];
        assign off_dly = st_r.dly[2 * gi + 1];
      end
      else
      begin : g_nodly
        assign on_dly  = 16'h0000;
        assign off_dly = 16'h0000;
      end
      if (gi < 4)
      begin : g_plo
        assign pol_bits[gi] = st_r.pol_hi[0] & 1'b0 | st_r.pol_lo[gi * dit_pkg::POL_DIGIT];
      end
      else
      begin : g_phi
        assign pol_bits[gi] = st_r.pol_hi[(gi - 4) * dit_pkg::POL_DIGIT];
      end
      // pin level to contact state, then polarity, ahead of the filter
      assign pre_lvl[gi] = st_r.sync2[gi] ^ st_r.oc_level ^ pol_bits[gi];
      dit_in_chan i_dit_in_chan (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .level_in   (pre_lvl[gi]),
        .tick_in    (st_r.tick),
        .filt_ms_in (st_r.filt_ms),
        .on_dly_in  (on_dly),
        .off_dly_in (off_dly),
        .level_out  (chan_lvl[gi])
      );
      assign act[gi] = chan_lvl[gi] | (st_r.vactive[gi] & st_r.vvalue[gi]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // function decode
  // ---------------------------------------------------------------
  always_comb
  begin
    hit = '0;
    for (int i = 0; i < 8; i++)
    begin
      if (act[i])
        hit[st_r.fn_sel[i]] = 1'b1;
    end
  end

  assign mode    = st_r.ctrl[dit_pkg::CF_MODE_LSB +: 2];
  assign aux_src = st_r.ctrl[dit_pkg::CF_AUX_LSB +: 3];

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt       = st_r;
    vec          = 1'b0;
    st_nxt.sync1 = term_pins_in;
    st_nxt.sync2 = st_r.sync1;

    // millisecond timebase for filter and delays
    st_nxt.tick = 1'b0;
    if (st_r.tick_cnt >= 17'(TICK_CYCLES - 1))
    begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end
    else
      st_nxt.tick_cnt = st_r.tick_cnt + 17'h0_0001;

    // register writes
    if (bus_in.wr)
    begin
      case (bus_in.addr)
        dit_pkg::A_OC_LEVEL: st_nxt.oc_level = bus_in.wdata[0];
        dit_pkg::A_POL_LO:   st_nxt.pol_lo   = bus_in.wdata & 16'h1111;
        dit_pkg::A_POL_HI:   st_nxt.pol_hi   = bus_in.wdata & 16'h1111;
        dit_pkg::A_WIRING:   st_nxt.wiring   = bus_in.wdata[1:0];
        dit_pkg::A_FILTER:   st_nxt.filt_ms  = bus_in.wdata;
        dit_pkg::A_VACTIVE:  st_nxt.vactive  = bus_in.wdata[7:0];
        dit_pkg::A_VVALUE:   st_nxt.vvalue   = bus_in.wdata[7:0];
        dit_pkg::A_CTRL:     st_nxt.ctrl     = bus_in.wdata[10:0];
        default:
        begin
          if (bus_in.addr >= dit_pkg::A_DLY_BASE && bus_in.addr < dit_pkg::A_DLY_BASE + 6'd8)
            st_nxt.dly[3'(bus_in.addr - dit_pkg::A_DLY_BASE)] = bus_in.wdata;
          else if (bus_in.addr >= dit_pkg::A_FN_BASE && bus_in.addr < dit_pkg::A_VVALUE)
            st_nxt.fn_sel[bus_in.addr[2:0]] = bus_in.wdata[6:0];
        end
      endcase
    end

    // register reads, data in the following cycle
    st_nxt.rdata = 16'h0000;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        dit_pkg::A_OC_LEVEL: st_nxt.rdata = {15'h0000, st_r.oc_level};
        dit_pkg::A_POL_LO:   st_nxt.rdata = st_r.pol_lo;
        dit_pkg::A_POL_HI:   st_nxt.rdata = st_r.pol_hi;
        dit_pkg::A_WIRING:   st_nxt.rdata = {14'h0000, st_r.wiring};
        dit_pkg::A_FILTER:   st_nxt.rdata = st_r.filt_ms;
        dit_pkg::A_VACTIVE:  st_nxt.rdata = {8'h00, st_r.vactive};
        dit_pkg::A_VVALUE:   st_nxt.rdata = {8'h00, st_r.vvalue};
        dit_pkg::A_CTRL:     st_nxt.rdata = {5'h00, st_r.ctrl};
        dit_pkg::A_LEVELS:   st_nxt.rdata = {act, chan_lvl};
        dit_pkg::A_CMDSTAT:  st_nxt.rdata = {st_r.cmd.cmd_src, st_r.cmd.ctrl_mode,
                                             st_r.cmd.run, st_r.cmd.run_rev,
                                             st_r.cmd.coast_stop, st_r.cmd.zero_freq,
                                             st_r.cmd.ext_stop, st_r.cmd.emer_stop,
                                             st_r.cmd.aux_clear, st_r.cmd.torque_mode,
                                             st_r.cmd.torque_neg, st_r.cmd.motor2,
                                             2'b00};
        default:
        begin
          if (bus_in.addr >= dit_pkg::A_DLY_BASE && bus_in.addr < dit_pkg::A_DLY_BASE + 6'd8)
            st_nxt.rdata = st_r.dly[3'(bus_in.addr - dit_pkg::A_DLY_BASE)];
          else if (bus_in.addr >= dit_pkg::A_FN_BASE && bus_in.addr < dit_pkg::A_VVALUE)
            st_nxt.rdata = {9'h000, st_r.fn_sel[bus_in.addr[2:0]]};
        end
      endcase
    end

    // command source override, keypad first, release falls back
    if (hit[dit_pkg::F_KEYPAD])
      st_nxt.cmd.cmd_src = dit_pkg::CS_KEYPAD;
    else if (hit[dit_pkg::F_TERM])
      st_nxt.cmd.cmd_src = dit_pkg::CS_TERM;
    else if (hit[dit_pkg::F_COMM])
      st_nxt.cmd.cmd_src = dit_pkg::CS_COMM;
    else
      st_nxt.cmd.cmd_src = st_r.ctrl[dit_pkg::CF_SRC_LSB +: 2];
    st_nxt.cmd.comm_method = st_r.ctrl[dit_pkg::CF_COMM_LSB +: 3];

    // reverse inhibit: remember whether it came before reverse running
    if (!hit[dit_pkg::F_REVINH])
      st_nxt.rev_pre = 1'b0;
    else if (!rev_running_in)
      st_nxt.rev_pre = 1'b1;
    st_nxt.cmd.zero_freq  = hit[dit_pkg::F_REVINH] & st_r.rev_pre;
    st_nxt.cmd.coast_stop = hit[dit_pkg::F_RUNINH]
                          | (hit[dit_pkg::F_REVINH] & rev_running_in & ~st_r.rev_pre);

    st_nxt.cmd.ext_stop  = hit[dit_pkg::F_EXTSTP] & running_in;
    st_nxt.cmd.emer_stop = hit[dit_pkg::F_ESTOP];
    st_nxt.cmd.aux_clear = hit[dit_pkg::F_AUXCLR]
                         & (aux_src == dit_pkg::AUX_DIG0 || aux_src == dit_pkg::AUX_DIG7);

    // forced control mode, scalar wins if both asserted
    if (hit[dit_pkg::F_VF])
      st_nxt.cmd.ctrl_mode = dit_pkg::CM_VF;
    else if (hit[dit_pkg::F_FVC])
      st_nxt.cmd.ctrl_mode = dit_pkg::CM_FVC;
    else
      st_nxt.cmd.ctrl_mode = mode;
    vec = (st_nxt.cmd.ctrl_mode != dit_pkg::CM_VF);
    st_nxt.cmd.torque_mode = vec
                           & (hit[dit_pkg::F_SPDTRQ] ^ st_r.ctrl[dit_pkg::CF_STBASE]);
    st_nxt.cmd.torque_neg  = vec & st_nxt.cmd.torque_mode & hit[dit_pkg::F_TRQDIR];

    st_nxt.cmd.motor2       = hit[dit_pkg::F_MOTOR];
    st_nxt.cmd.wobble_pause = hit[dit_pkg::F_WPAUSE];
    st_nxt.cmd.wobble_reset = hit[dit_pkg::F_WRESET];
    st_nxt.cmd.count_reset  = hit[dit_pkg::F_CRESET];
    st_nxt.cmd.count_en     = hit[dit_pkg::F_CTRIG];
    st_nxt.cmd.energy_clear = hit[dit_pkg::F_ECLR];
    st_nxt.cmd.energy_hold  = hit[dit_pkg::F_EHOLD] & ~hit[dit_pkg::F_ECLR];
    st_nxt.cmd.length_count = hit[dit_pkg::F_LCOUNT];
    st_nxt.cmd.length_reset = hit[dit_pkg::F_LRESET];

    // run and direction wiring
    st_nxt.fwd_prev = hit[dit_pkg::F_FWD];
    st_nxt.rev_prev = hit[dit_pkg::F_REV];
    case (st_r.wiring)
      dit_pkg::WM_2W1:
      begin
        st_nxt.run_r = hit[dit_pkg::F_FWD] ^ hit[dit_pkg::F_REV];
        st_nxt.rev_r = hit[dit_pkg::F_REV] & ~hit[dit_pkg::F_FWD];
      end
      dit_pkg::WM_2W2:
      begin
        st_nxt.run_r = hit[dit_pkg::F_FWD];
        st_nxt.rev_r = hit[dit_pkg::F_REV];
      end
      dit_pkg::WM_3W1:
      begin
        // stop button input must carry function 5, else nothing latches
        if (!hit[dit_pkg::F_3W])
          st_nxt.run_r = 1'b0;
        else if (hit[dit_pkg::F_FWD] && !st_r.fwd_prev)
        begin
          st_nxt.run_r = 1'b1;
          st_nxt.rev_r = 1'b0;
        end
        else if (hit[dit_pkg::F_REV] && !st_r.rev_prev)
        begin
          st_nxt.run_r = 1'b1;
          st_nxt.rev_r = 1'b1;
        end
      end
      dit_pkg::WM_3W2:
      begin
        if (!hit[dit_pkg::F_3W])
          st_nxt.run_r = 1'b0;
        else if (hit[dit_pkg::F_FWD] && !st_r.fwd_prev)
          st_nxt.run_r = 1'b1;
        st_nxt.rev_r = hit[dit_pkg::F_REV];
      end
      default:
      begin
        st_nxt.run_r = 1'b0;
      end
    endcase
    // run inhibit gates the run request itself
    st_nxt.cmd.run     = st_r.run_r & ~hit[dit_pkg::F_RUNINH];
    st_nxt.cmd.run_rev = st_r.rev_r;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r          <= '0;
      st_r.oc_level <= dit_pkg::RST_OC_LEVEL[0];
      st_r.filt_ms  <= dit_pkg::RST_FILTER;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata_out = st_r.rdata;
  assign cmd_out   = st_r.cmd;

endmodule : dit_input_top
`default_nettype wire

// ==== dv/dit_input_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module dit_input_props (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // register port
  input  wire dit_pkg::dit_bus_t bus_in,
  input  wire logic [15:0]       rdata_out,
  // terminals and drive state
  input  wire logic [7:0]        term_pins_in,
  input  wire logic              running_in,
  input  wire logic              rev_running_in,
  // commands
  input  wire dit_pkg::dit_cmd_t cmd_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  // ---------------------------------------------------------------
  // last written aux source
  // ---------------------------------------------------------------
  logic [2:0] aux_r;
  logic       aux_ok;
  assign aux_ok = (aux_r == dit_pkg::AUX_DIG0) || (aux_r == dit_pkg::AUX_DIG7);
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      aux_r <= 3'h0;
    else if (bus_in.wr && bus_in.addr == dit_pkg::A_CTRL)
      aux_r <= bus_in.wdata[5:3];
  end

  a_rdata_idle: assert property (!bus_in.rd |=> rdata_out == 16'h0000)
    else $error("read data not zero outside a read");
  a_unmapped_rd: assert property (bus_in.rd && bus_in.addr == 6'h3f |=> rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_filter_rdback: assert property (bus_in.wr && bus_in.addr == dit_pkg::A_FILTER &&
    bus_in.wdata <= 16'h03e8 ##1 !bus_in.wr ##1 bus_in.rd && bus_in.addr == dit_pkg::A_FILTER
    |=> rdata_out == $past(bus_in.wdata, 3)) else $error("filter time read back wrong");
  a_pol_digits: assert property (bus_in.wr && bus_in.addr == dit_pkg::A_POL_HI ##1
    !bus_in.wr ##1 bus_in.rd && bus_in.addr == dit_pkg::A_POL_HI
    |=> (rdata_out & 16'heeee) == 16'h0000) else $error("polarity keeps non-digit bits");
  a_src_legal: assert property (cmd_out.cmd_src != 2'h3)
    else $error("illegal command source");
  a_energy_excl: assert property (cmd_out.energy_clear |-> !cmd_out.energy_hold)
    else $error("energy hold beside clear");
  a_torque_dir: assert property (cmd_out.torque_neg |-> cmd_out.torque_mode)
    else $error("torque sign outside torque mode");
  a_aux_gate: assert property (cmd_out.aux_clear |-> aux_ok || $past(aux_ok) ||
    $past(aux_ok, 2) || $past(aux_ok, 3)) else $error("aux clear with analog aux source");
endmodule : dit_input_props
`default_nettype wire

// ==== dv/dit_switch_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dit_switch_model (
  // contacts and open-circuit rail
  input  wire logic [7:0] closed_in,
  input  wire logic       oc_in,
  // terminal pins
  output logic [7:0]      pins_out
);
  // a closed contact pulls the pin to the rail opposite the open level
  assign pins_out = oc_in ? ~closed_in : closed_in;
endmodule : dit_switch_model
`default_nettype wire

// ==== dv/dit_input_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module dit_input_top_tb;
  logic              mclk_in = 1'b0;
  logic              rstn_in = 1'b0;
  dit_pkg::dit_bus_t bus = '0;
  logic [15:0]       rdata;
  logic [7:0]        closed = 8'h00;
  logic [7:0]        pins;
  logic              oc = 1'b1;
  logic              inv = 1'b0;
  logic              rev_run = 1'b0;
  logic              rd_q = 1'b0;
  dit_pkg::dit_cmd_t cmd;
  dit_pkg::dit_cmd_t last = '0;
  dit_pkg::dit_cmd_t cq[$];
  logic [15:0]       rq[$];
  logic [7:0]        cur = 8'h00;
  int                curf = 0;
  int                errors = 0;
  int                comparisons = 0;
  int                seed = 82;
  logic [5:0]  ra[8] = '{dit_pkg::A_OC_LEVEL, dit_pkg::A_POL_LO, dit_pkg::A_POL_HI,
    dit_pkg::A_WIRING, dit_pkg::A_FILTER, dit_pkg::A_VACTIVE, dit_pkg::A_DLY_BASE, 6'h3f};
  logic [15:0] rv[8] = '{dit_pkg::RST_OC_LEVEL, 16'h0000, 16'h0000, 16'h0000,
    dit_pkg::RST_FILTER, 16'h0000, 16'h0000, 16'h0000};
  logic [5:0]  wa[11] = '{6'h03, 6'h03, 6'h01, 6'h01, 6'h02, 6'h02, 6'h04, 6'h04,
    6'h05, 6'h05, 6'h3f};
  logic [15:0] wd[11] = '{16'h0003, 16'h0000, 16'hffff, 16'h0000, 16'hffff, 16'h0000,
    16'h03e8, 16'h000a, 16'h00ff, 16'h0000, 16'hffff};
  logic [15:0] we[11] = '{16'h0003, 16'h0000, 16'h1111, 16'h0000, 16'h1111, 16'h0000,
    16'h03e8, 16'h000a, 16'h00ff, 16'h0000, 16'h0000};
  // ctrl byte above, function below
  logic [15:0] tbl[22] = '{16'h0001, 16'h0002, 16'h002b, 16'h002c, 16'h002d, 16'h0037,
    16'h003c, 16'h003d,
    16'h003e, 16'h003f, 16'h0040, 16'h0041, 16'h0042, 16'h0043, 16'h0044, 16'h0027,
    16'h0028, 16'h002a, 16'h0046, 16'h062f, 16'h0630, 16'h8026};

  dit_switch_model i_dit_switch_model (.closed_in(closed), .oc_in(oc), .pins_out(pins));
  dit_input_top #(.TICK_CYCLES(10)) i_dit_input_top (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .bus_in(bus), .rdata_out(rdata), .term_pins_in(pins), .running_in(1'b1),
    .rev_running_in(rev_run), .cmd_out(cmd));

  initial forever #5 mclk_in = ~mclk_in;
  // spare inputs have no function but keep the sync path busy
  always @(posedge mclk_in) closed[7:4] <= 4'($random(seed));

  // ---------------------------------------------------------------
  // expectations and checks
  // ---------------------------------------------------------------
  function automatic dit_pkg::dit_cmd_t exp_of(input logic [7:0] c, input int f);
    dit_pkg::dit_cmd_t e;
    e = '0;
    e.cmd_src = c[7:6];
    e.ctrl_mode = c[1:0];
    case (f)
      dit_pkg::F_FWD:    e.run = 1'b1;
      dit_pkg::F_REV:    {e.run, e.run_rev} = 2'b11;
      dit_pkg::F_KEYPAD: e.cmd_src = dit_pkg::CS_KEYPAD;
      dit_pkg::F_TERM:   e.cmd_src = dit_pkg::CS_TERM;
      dit_pkg::F_COMM:   e.cmd_src = dit_pkg::CS_COMM;
      dit_pkg::F_REVINH:
        if (rev_run) e.coast_stop = 1'b1;
        else e.zero_freq = 1'b1;
      dit_pkg::F_RUNINH: e.coast_stop = 1'b1;
      dit_pkg::F_EXTSTP: e.ext_stop = 1'b1;
      dit_pkg::F_AUXCLR: e.aux_clear = 1'b1;
      dit_pkg::F_TRQDIR: e.torque_neg = 1'b1;
      dit_pkg::F_MOTOR:  e.motor2 = 1'b1;
      dit_pkg::F_ESTOP:  e.emer_stop = 1'b1;
      dit_pkg::F_WPAUSE: e.wobble_pause = 1'b1;
      dit_pkg::F_WRESET: e.wobble_reset = 1'b1;
      dit_pkg::F_CRESET: e.count_reset = 1'b1;
      dit_pkg::F_CTRIG:  e.count_en = 1'b1;
      dit_pkg::F_ECLR:   e.energy_clear = 1'b1;
      dit_pkg::F_EHOLD:  e.energy_hold = 1'b1;
      dit_pkg::F_LCOUNT: e.length_count = 1'b1;
      dit_pkg::F_LRESET: e.length_reset = 1'b1;
      dit_pkg::F_VF:     e.ctrl_mode = dit_pkg::CM_VF;
      dit_pkg::F_FVC:    e.ctrl_mode = dit_pkg::CM_FVC;
      default:           e.run = 1'b0;
    endcase
    e.torque_mode = (e.ctrl_mode != dit_pkg::CM_VF) && (c[2] ^ (f == dit_pkg::F_SPDTRQ));
    return e;
  endfunction : exp_of

  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask : fail

  always @(posedge mclk_in)
  begin
    if (rd_q)
    begin
      comparisons++;
      if (rdata !== rq.pop_front()) fail("read data mismatch");
    end
    if (cmd !== last)
    begin
      comparisons++;
      if (cq.size() == 0) fail("unexpected command change");
      else if (cmd !== cq.pop_front()) fail("command mismatch");
    end
    last = cmd;
    rd_q = bus.rd;
  end

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk_in);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge mclk_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    rq.push_back(e);
    @(posedge mclk_in);
    bus.rd <= 1'b0;
  endtask : rd

  // change must land no earlier than lo and no later than hi cycles
  task automatic wait_q(input int lo, input int hi);
    int k;
    k = 0;
    while (k < hi && cq.size() > 0)
    begin
      @(posedge mclk_in);
      #1;
      k++;
    end
    if (k < lo) fail("command changed early");
    if (cq.size() > 0) fail("command did not change");
    cq.delete();
  endtask : wait_q

  task automatic pin(input logic on, input int lo, input int hi);
    cq.push_back(exp_of(cur, (on ^ inv) ? curf : 0));
    closed[0] <= on;
    wait_q(lo, hi);
  endtask : pin

  task automatic regchg(input logic [5:0] a, input logic [15:0] d, input int f, input int hi);
    cq.push_back(exp_of(cur, f));
    wr(a, d);
    wait_q(0, hi);
  endtask : regchg

  task automatic tally_and_finish;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #150000;
    fail("watchdog expired");
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rstn_in <= 1'b1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (wa[i])
    begin
      wr(wa[i], wd[i]);
      rd(wa[i], we[i]);
    end
    curf = dit_pkg::F_RUNINH;
    wr(dit_pkg::A_FN_BASE, 16'h002b);
    pin(1'b1, 0, 300);
    pin(1'b0, 0, 300);
    oc <= 1'b0;
    wr(dit_pkg::A_OC_LEVEL, 16'h0000);
    repeat (300) @(posedge mclk_in);
    pin(1'b1, 0, 300);
    pin(1'b0, 0, 300);
    inv = 1'b1;
    regchg(dit_pkg::A_POL_LO, 16'h0001, curf, 300);
    pin(1'b1, 0, 300);
    inv = 1'b0;
    regchg(dit_pkg::A_POL_LO, 16'h0000, curf, 300);
    pin(1'b0, 0, 300);
    wr(dit_pkg::A_FILTER, 16'h0005);
    closed[0] <= 1'b1;
    repeat (20) @(posedge mclk_in);
    closed[0] <= 1'b0;
    repeat (100) @(posedge mclk_in);
    pin(1'b1, 35, 200);
    pin(1'b0, 35, 200);
    wr(dit_pkg::A_FILTER, 16'h0000);
    foreach (tbl[i])
    begin
      if (tbl[i][15:8] != cur)
      begin
        cur = tbl[i][15:8];
        regchg(dit_pkg::A_CTRL, {8'h00, cur}, 0, 30);
      end
      curf = int'(tbl[i][7:0]);
      wr(dit_pkg::A_FN_BASE, {8'h00, tbl[i][7:0]});
      pin(1'b1, 0, 30);
      pin(1'b0, 0, 30);
    end
    // reverse inhibit asserted while already running in reverse
    rev_run <= 1'b1;
    curf = dit_pkg::F_REVINH;
    wr(dit_pkg::A_FN_BASE, 16'h002a);
    pin(1'b1, 0, 30);
    pin(1'b0, 0, 30);
    rev_run <= 1'b0;
    curf = dit_pkg::F_RUNINH;
    wr(dit_pkg::A_FN_BASE, 16'h002b);
    wr(dit_pkg::A_DLY_BASE, 16'h0001);
    pin(1'b1, 950, 1200);
    pin(1'b0, 0, 30);
    wr(dit_pkg::A_FN_BASE + 6'h01, 16'h0037);
    wr(dit_pkg::A_VVALUE, 16'h0002);
    repeat (30) @(posedge mclk_in);
    regchg(dit_pkg::A_VACTIVE, 16'h0002, dit_pkg::F_MOTOR, 30);
    regchg(dit_pkg::A_VVALUE, 16'h0000, 0, 30);
    // three-wire: stop contact on virtual input 2, run latched by input 1
    wr(dit_pkg::A_FN_BASE + 6'h01, 16'h0005);
    wr(dit_pkg::A_VVALUE, 16'h0002);
    wr(dit_pkg::A_WIRING, 16'h0002);
    curf = dit_pkg::F_FWD;
    wr(dit_pkg::A_FN_BASE, 16'h0001);
    pin(1'b1, 950, 1200);
    regchg(dit_pkg::A_VVALUE, 16'h0000, 0, 30);
    tally_and_finish();
  end
endmodule : dit_input_top_tb

bind dit_input_top dit_input_props i_dit_input_props (.mclk_in(mclk_in), .rstn_in(rstn_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .term_pins_in(term_pins_in),
  .running_in(running_in), .rev_running_in(rev_running_in), .cmd_out(cmd_out));
`default_nettype wire
